// ---- sim/ext_device_model.sv ----
// Behavioural external memory watching the four select lines
`timescale 1ns/100ps
module ext_device_model (
  input wire logic clk_in,
  input wire logic address_strobe_n_in,
  input wire logic [3:0] select_n_in,
  output logic bad_out
);
  // ----------------------------------------------------------------
  // Bus contention and stale select watch
  // ----------------------------------------------------------------
  int idle_cnt = 0; // Cycles since strobe went high
  initial bad_out = 1'b0;
  // Two devices on the data bus, or a select left on while idle
  always @(posedge clk_in) begin
    idle_cnt <= address_strobe_n_in ? idle_cnt + 1 : 0;
    if ($countones(~select_n_in) > 1) begin
      bad_out <= 1'b1;
    end
    if (idle_cnt > 6 && select_n_in !== 4'hF) begin
      bad_out <= 1'b1;
    end
  end
endmodule // ext_device_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the chip-select decoder
`timescale 1ns/100ps
module tb_top import select_decoder_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sys_reset_in = 1'b0;
  logic sys_halt_in = 1'b0;
  logic cpu_disable_in = 1'b0;
  logic address_strobe_n_in = 1'b1;
  logic [ADDR_HI:0] bus_addr_in = '0;
  logic [2:0] space_code_in = 3'h6;
  logic bus_write_in = 1'b0;
  logic on_chip_in = 1'b0;
  logic [3:0] select_n_out;
  logic bus_fault_out;
  logic transfer_acknowledge_out;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic dev_bad;
  logic [31:0] rdq; // Last read data
  logic [31:0] lfsr = 32'hDC08;
  int n_fail = 0;
  int tests_run = 0;
  int bw[4]; // Model base words
  int ow[4]; // Model option words
  int ctl; // Model control word
  always #2.5 clk_in = ~clk_in;
  chip_select_decoder i_chip_select_decoder (.clk_in(clk_in), .reset_in(reset_in),
    .clk_en_in(1'b1), .sys_reset_in(sys_reset_in), .sys_halt_in(sys_halt_in),
    .cpu_disable_in(cpu_disable_in), .address_strobe_n_in(address_strobe_n_in),
    .bus_addr_in(bus_addr_in), .space_code_in(space_code_in), .bus_write_in(bus_write_in),
    .on_chip_in(on_chip_in), .select_n_out(select_n_out), .bus_fault_out(bus_fault_out),
    .transfer_acknowledge_out(transfer_acknowledge_out), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  ext_device_model i_ext_device_model (.clk_in(clk_in),
    .address_strobe_n_in(address_strobe_n_in), .select_n_in(select_n_out), .bad_out(dev_bad));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] mval(input logic [7:0] a);
    if (a == 8'h20) return ctl;
    if (a < 8'h20) return a[2] ? ow[a[4:3]] : bw[a[4:3]];
    return 32'h0; // Unmapped reads zero
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic done(input string name);
    $display("End of test %s", name);
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // AHB-Lite single word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    rdq = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    chk("config fault", 32'h0, {30'h0, hresp, bus_fault_out});
    if (a == 8'h20) ctl = (ctl & 3 & ~d) | (d & 12);
    else if (a[2]) ow[a[4:3]] = d[15:0];
    else bw[a[4:3]] = d[15:0];
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0);
    chk("register", mval(a), rdq);
  endtask
  task automatic rd_all();
    for (int i = 0; i < 9; i++) rd(8'(4 * i));
    rd(8'h3C);
  endtask
  task automatic mreset(input logic dis);
    for (int i = 0; i < 4; i++) begin
      bw[i] = (i == 0 && !dis) ? BASE_RESET_CH0 : BASE_RESET_OTHER;
      ow[i] = OPT_RESET;
    end
    ctl = 0;
  endtask
  task automatic sysrst(input logic rst, input logic halt, input logic dis);
    @(posedge clk_in);
    sys_reset_in <= rst;
    sys_halt_in <= halt;
    cpu_disable_in <= dis;
    repeat (6) @(posedge clk_in);
    sys_reset_in <= 1'b0;
    sys_halt_in <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
  // One system bus cycle checked against the model
  task automatic cyc(input logic [23:0] a, input logic [2:0] sp, input logic w, input logic oc);
    int e, cnt, n;
    logic viol, flt, hit;
    e = 4;
    cnt = 0;
    viol = 0;
    for (int i = 3; i >= 0; i--) begin
      hit = bw[i][0] && !oc && sp != 3'h7 && (!ow[i][0] || sp == bw[i][15:13])
        && (((a[23:13] ^ bw[i][12:2]) & ow[i][12:2]) == 11'h0);
      if (hit && w && ow[i][1] && !bw[i][1]) viol = 1'b1;
      if (hit && ow[i][1] && bw[i][1] != w) hit = 1'b0;
      if (hit) begin
        e = i;
        cnt++;
      end
    end
    flt = (cnt > 1 && ctl[2]) || (viol && ctl[3]);
    if (viol && ctl[3]) e = 4;
    ctl = ctl | {viol, cnt > 1};
    @(posedge clk_in);
    bus_addr_in <= a;
    space_code_in <= sp;
    bus_write_in <= w;
    on_chip_in <= oc;
    repeat (3) @(posedge clk_in);
    address_strobe_n_in <= 1'b0;
    for (n = 0; n < 8 && select_n_out === 4'hF && bus_fault_out !== 1'b1; n++) tick();
    chk("select", {28'h0, e == 4 ? 4'hF : ~(4'h1 << e)}, {28'h0, select_n_out});
    chk("fault", {31'h0, flt}, {31'h0, bus_fault_out});
    if (e < 4 && !flt && ow[e][15:13] != 7) begin
      for (n = 0; n < 12 && transfer_acknowledge_out !== 1'b1; n++) tick();
      chk("ack wait", ow[e][15:13] + 1, n);
    end
    @(posedge clk_in);
    address_strobe_n_in <= 1'b1;
    for (n = 0; n < 8 && select_n_out !== 4'hF; n++) tick();
    chk("released", 32'hF, {28'h0, select_n_out});
    chk("device bus", 32'h0, {31'h0, dev_bad});
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    mreset(1'b0);
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    rd_all();
    done("reset values");
    cyc(24'h001FFF, 3'h6, 1'b0, 1'b0);
    cyc(24'h002000, 3'h6, 1'b0, 1'b0);
    cyc(24'h000100, 3'h6, 1'b0, 1'b1);
    cyc(24'h000100, 3'h5, 1'b0, 1'b0);
    wr(8'h04, 32'hDFFC);
    for (int s = 0; s < 8; s++) cyc(24'h000040, 3'(s), 1'b0, 1'b0);
    done("space codes");
    wr(8'h00, 32'hC003);
    cyc(24'h000200, 3'h6, 1'b1, 1'b0);
    wr(8'h04, 32'hDFFF);
    cyc(24'h000200, 3'h6, 1'b0, 1'b0);
    cyc(24'h000200, 3'h6, 1'b1, 1'b0);
    wr(8'h00, 32'hC001);
    wr(8'h20, 32'h8);
    cyc(24'h000200, 3'h6, 1'b1, 1'b0);
    rd(8'h20);
    wr(8'h20, 32'h2);
    cyc(24'h000200, 3'h6, 1'b1, 1'b0);
    rd(8'h20);
    done("direction");
    wr(8'h04, 32'hDFFD);
    wr(8'h08, 32'hC001);
    cyc(24'h000300, 3'h6, 1'b0, 1'b0);
    wr(8'h20, 32'h5);
    cyc(24'h000300, 3'h6, 1'b0, 1'b0);
    rd(8'h20);
    wr(8'h00, 32'hC000);
    cyc(24'h000300, 3'h6, 1'b0, 1'b0);
    done("overlap");
    for (int k = 0; k < 24; k++) begin
      lfsr = nxt(lfsr);
      wr({3'h0, lfsr[1:0], 3'h0}, {16'h0, lfsr[31:16]});
      wr({3'h0, lfsr[1:0], 3'h4}, {16'h0, lfsr[15:0]});
      cyc({bw[lfsr[1:0]][12:2], lfsr[14:2]}, bw[lfsr[1:0]][15:13], 1'b0, &lfsr[3:2]);
    end
    rd_all();
    done("random");
    wr(8'h08, 32'h1234);
    sysrst(1'b1, 1'b0, 1'b0);
    rd(8'h08);
    sysrst(1'b1, 1'b1, 1'b1);
    mreset(1'b1);
    rd_all();
    cyc(24'h000100, 3'h6, 1'b0, 1'b0);
    sysrst(1'b1, 1'b1, 1'b0);
    mreset(1'b0);
    rd(8'h00);
    done("system reset");
    finish_test();
  end
endmodule // tb_top

// ---- verilog/chip_select_decoder.sv ----
// Four-channel chip-select decoder with AHB-Lite register slave
`timescale 1ns/100ps
module chip_select_decoder
  import select_decoder_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Reset pin pair; both high is a total system reset
  input wire logic sys_reset_in,
  input wire logic sys_halt_in,
  input wire logic cpu_disable_in,
  // System bus cycle, from pins
  input wire logic address_strobe_n_in,
  input wire logic [ADDR_HI:0] bus_addr_in,
  input wire logic [2:0] space_code_in,
  input wire logic bus_write_in,
  input wire logic on_chip_in,
  output logic [CHANNELS-1:0] select_n_out,
  output logic bus_fault_out,
  output logic transfer_acknowledge_out,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] as_sync_r; // Strobe, two stages
  logic [1:0] rst_sync_r; // Reset pin
  logic [1:0] halt_sync_r; // Halt pin
  logic [1:0] dis_sync_r; // Processor-disabled strap
  cycle_info_t cyc_meta_r; // First stage of cycle info
  cycle_info_t cyc_r; // Second stage of cycle info
  logic as_low_r; // Previous synced strobe low
  logic total_reset; // Total system reset
  logic strobe_fall; // Cycle start
  logic strobe_rise; // Cycle end

  // Two flops on every pin input
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      as_sync_r <= 2'h3;
      rst_sync_r <= 2'h0;
      halt_sync_r <= 2'h0;
      dis_sync_r <= 2'h0;
      cyc_meta_r <= '0;
      cyc_r <= '0;
    end else if (clk_en_in) begin
      as_sync_r <= {as_sync_r[0], address_strobe_n_in};
      rst_sync_r <= {rst_sync_r[0], sys_reset_in};
      halt_sync_r <= {halt_sync_r[0], sys_halt_in};
      dis_sync_r <= {dis_sync_r[0], cpu_disable_in};
      cyc_meta_r <= '{bus_addr_in, space_code_in, bus_write_in, on_chip_in};
      cyc_r <= cyc_meta_r;
    end
  end

  // Previous strobe state for edge detection
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      as_low_r <= 1'b0;
    end else if (clk_en_in) begin
      as_low_r <= ~as_sync_r[1];
    end
  end

  assign total_reset = rst_sync_r[1] & halt_sync_r[1];
  assign strobe_fall = ~as_sync_r[1] & ~as_low_r;
  assign strobe_rise = as_sync_r[1] & as_low_r;

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  base_match_word_t base_r [CHANNELS];
  option_word_t opt_r [CHANNELS];
  logic overlap_flag_r; // Conflict seen
  logic protect_flag_r; // Write-protect violation seen
  logic overlap_fault_enable_r;
  logic protect_fault_enable_r;

  // AHB address phase capture
  logic wr_pend_r; // Write data phase pending
  logic [7:0] wr_addr_r; // Captured write address
  logic [7:0] rd_addr; // Read address in address phase
  logic take; // Valid transfer this edge
  logic [31:0] rd_word; // Decoded read word
  logic [2:0] chan_idx; // Channel of write
  logic wr_base; // Write hits a base word
  logic wr_opt; // Write hits an option word
  logic wr_ctrl; // Write hits control word

  assign take = hsel & hready & htrans[1];
  assign rd_addr = haddr[7:0];
  assign chan_idx = wr_addr_r[5:3];
  assign wr_base = wr_pend_r && wr_addr_r < REG_CONTROL && wr_addr_r[2] == 1'b0;
  assign wr_opt = wr_pend_r && wr_addr_r < REG_CONTROL && wr_addr_r[2] == 1'b1;
  assign wr_ctrl = wr_pend_r && wr_addr_r == REG_CONTROL;

  // Capture write address phase; always zero wait states
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (clk_en_in) begin
      wr_pend_r <= take & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Base and option registers; reset by reset_in or by total reset
  always_ff @(posedge clk_in) begin
    if (reset_in || (clk_en_in && total_reset)) begin
      for (int i = 0; i < CHANNELS; i++) begin
        // Space 110, base zero, read-only, ch0 only enabled, none if processor disabled
        base_r[i] <= (i == 0) ? BASE_RESET_CH0 : BASE_RESET_OTHER;
        if (dis_sync_r[1]) begin
          base_r[i].enable <= 1'b0;
        end
        // Six waits, mask ones, dirmask 0, space compare 1
        opt_r[i] <= OPT_RESET;
      end
    end else if (clk_en_in) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (wr_base && chan_idx == 3'(i)) begin
          base_r[i] <= hwdata[15:0];
        end
        if (wr_opt && chan_idx == 3'(i)) begin
          opt_r[i] <= hwdata[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Match logic
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] place_hit; // Address and space match, any direction
  logic [CHANNELS-1:0] hit; // Raw per-channel match
  logic [CHANNELS-1:0] grant; // Priority winner
  logic [CHANNELS-1:0] sel_active_r; // Latched active select
  logic [2:0] wait_code_r; // Wait code of active cycle
  logic conflict; // Two or more hits
  logic protect_hit; // Write lands on a read-only match
  logic cycle_ok; // Cycle may match at all

  // Off-chip, not interrupt acknowledge, space usable
  assign cycle_ok = ~cyc_r.on_chip && cyc_r.space_code != SPACE_INT_ACK;

  // Per-channel compare
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      place_hit[i] = cycle_ok && base_r[i].enable
        // Masked compare of A23..A13 sets block size
        && (((cyc_r.addr[ADDR_HI:ADDR_LO] ^ base_r[i].base_addr) & opt_r[i].addr_mask) == '0)
        // Space compare; reserved code never matches
        && (~opt_r[i].space_compare_enable
            || (cyc_r.space_code == base_r[i].space_code
                && base_r[i].space_code != SPACE_RESERVED));
      // Direction checked only where mask set
      hit[i] = place_hit[i] && (~opt_r[i].direction_mask || base_r[i].direction == cyc_r.write);
    end
  end

  // Fixed priority, lowest index wins
  always_comb begin
    grant = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

  assign conflict = $countones(hit) > 1;

  // Write to a read-only channel among the matches
  always_comb begin
    protect_hit = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (place_hit[i] && cyc_r.write && opt_r[i].direction_mask && ~base_r[i].direction) begin
        protect_hit = 1'b1;
      end
    end
  end

  // Selects latched at strobe fall, released at strobe rise
  always_ff @(posedge clk_in) begin
    if (reset_in || (clk_en_in && total_reset)) begin
      sel_active_r <= '0;
      wait_code_r <= 3'h0;
    end else if (clk_en_in) begin
      if (strobe_rise) begin
        sel_active_r <= '0;
      end else if (strobe_fall) begin
        // Armed protect fault drops every line
        sel_active_r <= (protect_hit && protect_fault_enable_r) ? '0 : grant;
        for (int i = 0; i < CHANNELS; i++) begin
          if (grant[i]) begin
            wait_code_r <= opt_r[i].wait_code;
          end
        end
      end
    end
  end

  assign select_n_out = ~sel_active_r;

  // ----------------------------------------------------------------
  // Fault and flags
  // ----------------------------------------------------------------
  logic fault_r; // Bus fault for current cycle
  logic fault_cause; // Armed fault event this cycle

  // Register writes come from the slave, never off-chip cycles
  assign fault_cause = cycle_ok && strobe_fall
    && ((conflict && overlap_fault_enable_r) || (protect_hit && protect_fault_enable_r));

  // Fault held until strobe rises
  always_ff @(posedge clk_in) begin
    if (reset_in || (clk_en_in && total_reset)) begin
      fault_r <= 1'b0;
    end else if (clk_en_in) begin
      if (strobe_rise) begin
        fault_r <= 1'b0;
      end else if (fault_cause) begin
        fault_r <= 1'b1;
      end
    end
  end

  assign bus_fault_out = fault_r;

  // Control word: sticky flags write-one-clear, set wins
  always_ff @(posedge clk_in) begin
    if (reset_in || (clk_en_in && total_reset)) begin
      overlap_flag_r <= 1'b0;
      protect_flag_r <= 1'b0;
      overlap_fault_enable_r <= 1'b0;
      protect_fault_enable_r <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_ctrl) begin
        overlap_fault_enable_r <= hwdata[CTRL_OVERLAP_EN];
        protect_fault_enable_r <= hwdata[CTRL_PROTECT_EN];
        if (hwdata[CTRL_OVERLAP_FLAG]) begin
          overlap_flag_r <= 1'b0;
        end
        if (hwdata[CTRL_PROTECT_FLAG]) begin
          protect_flag_r <= 1'b0;
        end
      end
      if (strobe_fall && conflict) begin
        overlap_flag_r <= 1'b1;
      end
      if (strobe_fall && protect_hit) begin
        protect_flag_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal acknowledge wait states
  // ----------------------------------------------------------------
  ack_state_t ack_state_r;
  logic [2:0] wait_cnt_r; // Waits counted so far, up from zero
  logic ack_r; // Acknowledge level

  // Count programmed waits then hold acknowledge until strobe rises
  always_ff @(posedge clk_in) begin
    if (reset_in || (clk_en_in && total_reset)) begin
      ack_state_r <= ST_IDLE;
      wait_cnt_r <= 3'h0;
      ack_r <= 1'b0;
    end else if (clk_en_in) begin
      case (ack_state_r)
        ST_IDLE: begin
          if (strobe_fall && |grant && ~fault_cause) begin
            wait_cnt_r <= 3'h0;
            ack_state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (strobe_rise) begin
            ack_state_r <= ST_IDLE;
          end else if (wait_code_r == WAIT_EXTERNAL) begin
            ack_state_r <= ST_DONE;
          end else if (wait_cnt_r == wait_code_r) begin
            ack_r <= 1'b1;
            ack_state_r <= ST_DONE;
          end else begin
            wait_cnt_r <= wait_cnt_r + 3'h1;
          end
        end
        ST_DONE: begin
          if (strobe_rise) begin
            ack_r <= 1'b0;
            ack_state_r <= ST_IDLE;
          end
        end
        default: begin
          ack_state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign transfer_acknowledge_out = ack_r;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_addr == REG_CONTROL) begin
      rd_word[CTRL_OVERLAP_FLAG] = overlap_flag_r;
      rd_word[CTRL_PROTECT_FLAG] = protect_flag_r;
      rd_word[CTRL_OVERLAP_EN] = overlap_fault_enable_r;
      rd_word[CTRL_PROTECT_EN] = protect_fault_enable_r;
      rd_word[CTRL_WAITING] = (ack_state_r == ST_WAIT);
    end else if (rd_addr < REG_CONTROL) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (rd_addr[5:3] == 3'(i)) begin
          rd_word[15:0] = rd_addr[2] ? 16'(opt_r[i]) : 16'(base_r[i]);
        end
      end
    end
  end

  // Read data registered for the data phase
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en_in && take && ~hwrite) begin
      hrdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_one_hot_select: assert property (@(posedge clk_in) disable iff (reset_in)
    $countones(~select_n_out) <= 1) else $error("more than one select");

  chk_select_on_fall: assert property (@(posedge clk_in) disable iff (reset_in)
    (clk_en_in && strobe_fall && ~total_reset && |grant && ~protect_hit) |=>
    (~select_n_out == $past(grant))) else $error("select not driven");

  chk_select_release: assert property (@(posedge clk_in) disable iff (reset_in)
    (clk_en_in && strobe_rise) |=> select_n_out == '1)
    else $error("select held after strobe");

  chk_onchip_quiet: assert property (@(posedge clk_in) disable iff (reset_in)
    (clk_en_in && strobe_fall && cyc_r.on_chip) |=> select_n_out == '1)
    else $error("on-chip cycle selected");

  chk_intack_quiet: assert property (@(posedge clk_in) disable iff (reset_in)
    (cyc_r.space_code == SPACE_INT_ACK) |-> hit == '0)
    else $error("match on interrupt ack");

  chk_conflict_flag: assert property (@(posedge clk_in) disable iff (reset_in)
    (clk_en_in && strobe_fall && conflict && ~total_reset) |=> overlap_flag_r)
    else $error("conflict flag not set");

  chk_protect_fault: assert property (@(posedge clk_in) disable iff (reset_in)
    (clk_en_in && strobe_fall && protect_hit && protect_fault_enable_r && ~total_reset)
    |=> (bus_fault_out && protect_flag_r && select_n_out == '1))
    else $error("protect violation missed");

  chk_reset_defaults: assert property (@(posedge clk_in)
    (clk_en_in && total_reset && ~reset_in && ~dis_sync_r[1]) |=>
    (base_r[0] == BASE_RESET_CH0 && opt_r[0] == OPT_RESET))
    else $error("reset defaults wrong");

  chk_disabled_mode: assert property (@(posedge clk_in)
    (clk_en_in && total_reset && ~reset_in && dis_sync_r[1]) |=> ~base_r[0].enable)
    else $error("channel 0 enabled in disabled mode");

  sequence seq_start_zero_wait;
    clk_en_in && ack_state_r == ST_WAIT && wait_code_r == 3'h0 && ~strobe_rise && ~total_reset;
  endsequence

  chk_zero_wait_ack: assert property (@(posedge clk_in) disable iff (reset_in)
    seq_start_zero_wait |=> transfer_acknowledge_out)
    else $error("zero-wait ack late");

endmodule // chip_select_decoder

// ---- verilog/select_decoder_pkg.sv ----
// Constants, types and register map for the chip-select decoder
package select_decoder_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CHANNELS = 4;
  localparam int ADDR_HI = 23;
  localparam int ADDR_LO = 13;
  localparam int ADDR_BITS = ADDR_HI - ADDR_LO + 1;

  // ----------------------------------------------------------------
  // Base word fields
  // ----------------------------------------------------------------
  localparam int BASE_SPACE_LSB = 13;
  localparam int BASE_ADDR_LSB = 2;
  localparam int BASE_DIR_BIT = 1;
  localparam int BASE_EN_BIT = 0;

  // ----------------------------------------------------------------
  // Option word fields
  // ----------------------------------------------------------------
  localparam int OPT_WAIT_LSB = 13;
  localparam int OPT_MASK_LSB = 2;
  localparam int OPT_DIRMASK_BIT = 1;
  localparam int OPT_SPACE_EN_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and special codes
  // ----------------------------------------------------------------
  localparam logic [15:0] BASE_RESET_CH0 = 16'hC001;
  localparam logic [15:0] BASE_RESET_OTHER = 16'hC000;
  localparam logic [15:0] OPT_RESET = 16'hDFFD;
  localparam logic [2:0] SPACE_RESERVED = 3'h7;
  localparam logic [2:0] SPACE_INT_ACK = 3'h7;
  localparam logic [2:0] WAIT_EXTERNAL = 3'h7;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_BASE0 = 8'h00;
  localparam logic [7:0] REG_OPT0 = 8'h04;
  localparam logic [7:0] REG_STRIDE = 8'h08;
  localparam logic [7:0] REG_CONTROL = 8'h20;
  localparam int CTRL_OVERLAP_FLAG = 0;
  localparam int CTRL_PROTECT_FLAG = 1;
  localparam int CTRL_OVERLAP_EN = 2;
  localparam int CTRL_PROTECT_EN = 3;
  localparam int CTRL_WAITING = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] space_code;
    logic [ADDR_BITS-1:0] base_addr;
    logic direction;
    logic enable;
  } base_match_word_t;

  typedef struct packed {
    logic [2:0] wait_code;
    logic [ADDR_BITS-1:0] addr_mask;
    logic direction_mask;
    logic space_compare_enable;
  } option_word_t;

  typedef struct packed {
    logic [ADDR_HI:0] addr;
    logic [2:0] space_code;
    logic write;
    logic on_chip;
  } cycle_info_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} ack_state_t;

endpackage
